// ===== hdl/nfcm_mixer_top.sv
// nfcm_mixer_top: two-path oscillator mixer with its Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - two mixer paths, pair AB and pair CD, each with a full complex mixer.
// - each path has its own oscillator; AB and CD tuning and shift words are independent, gain and mix enable are shared.
// - each oscillator has a 32-bit tuning word written by software per pair.
// - each oscillator has a 16-bit phase shift word added to accumulator phase.
// - every clock the tuning word is added to the accumulator, wrapping at 2^32.
// - the selected sync event clears both phase accumulators to zero.
// - a 4-bit select field in the sync config word picks the sync source.
// - output frequency equals tuning word times sample clock over 2^32.
// - with mixing on, first channel is real part, second imaginary part.
// - real out is I cos minus Q sin; imaginary out is I sin plus Q cos.
// - phase shift equals two pi times the shift word over 2^16.
// - with mixing on, gain select scales outputs by 2^(sel-1): zero halves, one is unity.
module nfcm_mixer_top
  import nfcm_pkg::*;
#(
  parameter int DATA_W = NFCM_DATA_W
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_sync_pin,
  input wire logic i_aux_sync_pin,
  input wire logic i_frame_sync,
  input wire logic i_ab_valid,
  input wire logic [DATA_W-1:0] i_ab_re,
  input wire logic [DATA_W-1:0] i_ab_im,
  input wire logic i_cd_valid,
  input wire logic [DATA_W-1:0] i_cd_re,
  input wire logic [DATA_W-1:0] i_cd_im,
  output logic o_ab_valid,
  output logic [DATA_W-1:0] o_ab_re,
  output logic [DATA_W-1:0] o_ab_im,
  output logic o_cd_valid,
  output logic [DATA_W-1:0] o_cd_re,
  output logic [DATA_W-1:0] o_cd_im,
  output logic o_sync_event
);

  if (DATA_W != 16)
  begin : g_chk
    $error("nfcm_mixer_top: only 16-bit samples are supported");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] tw_ab;
    logic [31:0] tw_cd;
    logic [15:0] ps_ab;
    logic [15:0] ps_cd;
    logic [3:0] sel;
    logic gain;
    logic mix_en;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_last;
    logic sw_sync;
  } nfcm_top_st_t;

  nfcm_top_st_t st_q;
  nfcm_top_st_t st_d;
  logic req;
  logic take;
  logic [3:0] sync_src;
  logic sync_evt;
  logic [31:0] acc_ab;
  logic [31:0] acc_cd;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic nfcm_hit(input logic [4:0] addr, input logic [4:0] ofs);
    return addr[4:2] == ofs[4:2];
  endfunction

  function automatic logic [31:0] nfcm_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] nfcm_cfg_word(input logic [3:0] sel, input logic gain,
                                                input logic mix_en);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[NFCM_CFG_SEL_LSB +: 4] = sel;
    w[NFCM_CFG_GAIN_BIT] = gain;
    w[NFCM_CFG_MIXEN_BIT] = mix_en;
    return w;
  endfunction

  // ------------------------------------------------------------------
  // bus handshake: one wait state, the request is taken on the second edge
  // ------------------------------------------------------------------
  assign req = i_avs_read | i_avs_write;
  assign take = req & st_q.ack;
  assign o_avs_waitrequest = req & ~st_q.ack;
  assign o_avs_readdata = st_q.rdata;

  // only edges of the pin's second stage are seen; the first stage feeds nothing else
  always_comb
  begin
    sync_src = 4'h0;
    sync_src[NFCM_SRC_SW] = st_q.sw_sync;
    sync_src[NFCM_SRC_PIN] = st_q.pin_sync[0] & ~st_q.pin_last[0];
    sync_src[NFCM_SRC_FRAME] = i_frame_sync;
    sync_src[NFCM_SRC_AUX] = st_q.pin_sync[1] & ~st_q.pin_last[1];
  end

  assign sync_evt = |(st_q.sel & sync_src);
  assign o_sync_event = sync_evt;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.pin_meta = {i_aux_sync_pin, i_sync_pin};
    st_d.pin_sync = st_q.pin_meta;
    st_d.pin_last = st_q.pin_sync;
    st_d.sw_sync = 1'b0;
    st_d.ack = req & ~st_q.ack;
    // read data are captured in the wait cycle so they come from a flop
    if (i_avs_read & ~st_q.ack)
    begin
      if (nfcm_hit(i_avs_address, NFCM_OFS_TUNING_AB))
        st_d.rdata = st_q.tw_ab;
      else if (nfcm_hit(i_avs_address, NFCM_OFS_TUNING_CD))
        st_d.rdata = st_q.tw_cd;
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SHIFT_AB))
        st_d.rdata = {16'h0000, st_q.ps_ab};
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SHIFT_CD))
        st_d.rdata = {16'h0000, st_q.ps_cd};
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SYNC_CFG))
        st_d.rdata = nfcm_cfg_word(st_q.sel, st_q.gain, st_q.mix_en);
      else if (nfcm_hit(i_avs_address, NFCM_OFS_ACC_AB))
        st_d.rdata = acc_ab;
      else if (nfcm_hit(i_avs_address, NFCM_OFS_ACC_CD))
        st_d.rdata = acc_cd;
      else
        st_d.rdata = 32'h0000_0000;
    end
    if (take & i_avs_write)
    begin
      if (nfcm_hit(i_avs_address, NFCM_OFS_TUNING_AB))
        st_d.tw_ab = nfcm_merge(st_q.tw_ab, i_avs_writedata, i_avs_byteenable);
      else if (nfcm_hit(i_avs_address, NFCM_OFS_TUNING_CD))
        st_d.tw_cd = nfcm_merge(st_q.tw_cd, i_avs_writedata, i_avs_byteenable);
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SHIFT_AB))
        st_d.ps_ab = 16'(nfcm_merge({16'h0000, st_q.ps_ab}, i_avs_writedata,
                                    i_avs_byteenable));
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SHIFT_CD))
        st_d.ps_cd = 16'(nfcm_merge({16'h0000, st_q.ps_cd}, i_avs_writedata,
                                    i_avs_byteenable));
      else if (nfcm_hit(i_avs_address, NFCM_OFS_SYNC_CFG))
      begin
        if (i_avs_byteenable[0])
        begin
          st_d.sel = i_avs_writedata[NFCM_CFG_SEL_LSB +: 4];
          st_d.gain = i_avs_writedata[NFCM_CFG_GAIN_BIT];
          st_d.mix_en = i_avs_writedata[NFCM_CFG_MIXEN_BIT];
        end
        st_d.sw_sync = i_avs_byteenable[1] & i_avs_writedata[NFCM_CFG_SWSYNC_BIT];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      st_q <= '0;
      st_q.tw_ab <= NFCM_TUNING_RST;
      st_q.tw_cd <= NFCM_TUNING_RST;
      st_q.ps_ab <= NFCM_SHIFT_RST;
      st_q.ps_cd <= NFCM_SHIFT_RST;
      st_q.sel <= NFCM_SEL_RST;
      st_q.gain <= NFCM_GAIN_RST;
      st_q.mix_en <= NFCM_MIXEN_RST;
    end
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------------
  // the two mixer paths, each with its own oscillator
  // ------------------------------------------------------------------
  nfcm_path #(.DATA_W(DATA_W)) u_path_ab (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sync(sync_evt),
    .i_tuning(st_q.tw_ab),
    .i_phase_shift(st_q.ps_ab),
    .i_mix_en(st_q.mix_en),
    .i_gain_sel(st_q.gain),
    .i_valid(i_ab_valid),
    .i_re(i_ab_re),
    .i_im(i_ab_im),
    .o_valid(o_ab_valid),
    .o_re(o_ab_re),
    .o_im(o_ab_im),
    .o_phase_acc(acc_ab)
  );

  nfcm_path #(.DATA_W(DATA_W)) u_path_cd (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_sync(sync_evt),
    .i_tuning(st_q.tw_cd),
    .i_phase_shift(st_q.ps_cd),
    .i_mix_en(st_q.mix_en),
    .i_gain_sel(st_q.gain),
    .i_valid(i_cd_valid),
    .i_re(i_cd_re),
    .i_im(i_cd_im),
    .o_valid(o_cd_valid),
    .o_re(o_cd_re),
    .o_im(o_cd_im),
    .o_phase_acc(acc_cd)
  );

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic [31:0] ph_ab_chk;
  logic small_ab;
  logic wr_tw_ab;
  assign ph_ab_chk = acc_ab + {st_q.ps_ab, 16'h0000};
  assign small_ab = (i_ab_re[15] == i_ab_re[14]) && (i_ab_im[15] == i_ab_im[14]);
  assign wr_tw_ab = take && i_avs_write && nfcm_hit(i_avs_address, NFCM_OFS_TUNING_AB)
                    && (i_avs_byteenable == 4'hF);

  property p_acc_step;
    !sync_evt |=> (acc_ab == $past(acc_ab) + $past(st_q.tw_ab))
                  && (acc_cd == $past(acc_cd) + $past(st_q.tw_cd));
  endproperty
  a_acc_step: assert property (p_acc_step) else $error("accumulator did not step");

  property p_acc_clear;
    sync_evt |=> (acc_ab == 32'h0000_0000) && (acc_cd == 32'h0000_0000);
  endproperty
  a_acc_clear: assert property (p_acc_clear) else $error("sync did not clear");

  property p_pin_sync;
    (st_q.sel == 4'h2 && $rose(i_sync_pin)) ##1 (i_sync_pin && st_q.sel == 4'h2)
      |=> sync_evt;
  endproperty
  a_pin_sync: assert property (p_pin_sync) else $error("pin sync not seen");

  property p_no_source;
    (st_q.sel == 4'h0) |-> !sync_evt;
  endproperty
  a_no_source: assert property (p_no_source) else $error("sync with no source");

  property p_tw_write;
    wr_tw_ab |=> st_q.tw_ab == $past(i_avs_writedata);
  endproperty
  a_tw_write: assert property (p_tw_write) else $error("tuning word not stored");

  property p_indep;
    wr_tw_ab |=> $stable(st_q.tw_cd) && $stable(st_q.ps_cd);
  endproperty
  a_indep: assert property (p_indep) else $error("pair CD disturbed");

  property p_ps_write;
    (take && i_avs_write && nfcm_hit(i_avs_address, NFCM_OFS_SHIFT_CD)
     && i_avs_byteenable[1:0] == 2'h3) |=> st_q.ps_cd == $past(i_avs_writedata[15:0]);
  endproperty
  a_ps_write: assert property (p_ps_write) else $error("phase shift not stored");

  property p_latency;
    i_ab_valid |-> ##2 o_ab_valid;
  endproperty
  a_latency: assert property (p_latency) else $error("output valid late");

  property p_bypass;
    (!st_q.mix_en && i_ab_valid) |-> ##2 (o_ab_re == $past(i_ab_re, 2))
                                         && (o_ab_im == $past(i_ab_im, 2));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered data");

  property p_unity;
    // -16384 rounds up by one at unity gain, so it is left out here
    (st_q.mix_en && st_q.gain && i_ab_valid && small_ab && ph_ab_chk[31:26] == 6'h00
     && i_ab_re != 16'hC000 && i_ab_im != 16'hC000)
      |-> ##2 (o_ab_re == $past(i_ab_re, 2)) && (o_ab_im == $past(i_ab_im, 2));
  endproperty
  a_unity: assert property (p_unity) else $error("zero phase changed sample");

  property p_half;
    (st_q.mix_en && !st_q.gain && i_ab_valid && small_ab && !i_ab_re[0]
     && ph_ab_chk[31:26] == 6'h00)
      |-> ##2 o_ab_re == {$past(i_ab_re[15], 2), $past(i_ab_re[15:1], 2)};
  endproperty
  a_half: assert property (p_half) else $error("gain zero did not halve");

  property p_sat;
    (st_q.mix_en && i_ab_valid) |-> ##2 (o_ab_re != 16'h8000) && (o_ab_im != 16'h8000);
  endproperty
  a_sat: assert property (p_sat) else $error("output wrapped past full scale");

  property p_wait;
    (req && !st_q.ack) |-> o_avs_waitrequest ##1 (!req || !o_avs_waitrequest);
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");

  c_sync: cover property (sync_evt ##1 acc_ab == 32'h0000_0000);
  c_mixed: cover property (st_q.mix_en && i_ab_valid ##2 o_ab_valid);
  c_write: cover property (wr_tw_ab);

endmodule
`default_nettype wire

// ===== inc/nfcm_pkg.sv
// nfcm_pkg: shared constants of the dual numerically controlled mixer block
`default_nettype none
package nfcm_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int NFCM_DATA_W = 16;
  localparam int NFCM_NCO_W = 32;
  localparam int NFCM_PHASE_W = 16;
  localparam int NFCM_SEL_W = 4;
  localparam int NFCM_ADDR_W = 5;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [4:0] NFCM_OFS_TUNING_AB = 5'h00;
  localparam logic [4:0] NFCM_OFS_TUNING_CD = 5'h04;
  localparam logic [4:0] NFCM_OFS_SHIFT_AB = 5'h08;
  localparam logic [4:0] NFCM_OFS_SHIFT_CD = 5'h0C;
  localparam logic [4:0] NFCM_OFS_SYNC_CFG = 5'h10;
  localparam logic [4:0] NFCM_OFS_ACC_AB = 5'h14;
  localparam logic [4:0] NFCM_OFS_ACC_CD = 5'h18;

  // ------------------------------------------------------------------
  // sync_config_word field positions
  // ------------------------------------------------------------------
  localparam int NFCM_CFG_SEL_LSB = 0;
  localparam int NFCM_CFG_GAIN_BIT = 4;
  localparam int NFCM_CFG_MIXEN_BIT = 5;
  localparam int NFCM_CFG_SWSYNC_BIT = 8;

  // ------------------------------------------------------------------
  // sync source bit positions inside the select field
  // ------------------------------------------------------------------
  localparam int NFCM_SRC_SW = 0;
  localparam int NFCM_SRC_PIN = 1;
  localparam int NFCM_SRC_FRAME = 2;
  localparam int NFCM_SRC_AUX = 3;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] NFCM_TUNING_RST = 32'h0000_0000;
  localparam logic [15:0] NFCM_SHIFT_RST = 16'h0000;
  localparam logic [3:0] NFCM_SEL_RST = 4'h0;
  localparam logic NFCM_GAIN_RST = 1'b1;
  localparam logic NFCM_MIXEN_RST = 1'b1;

  // ------------------------------------------------------------------
  // timing: sample valid in to valid out, in clock edges
  // ------------------------------------------------------------------
  localparam int NFCM_MIX_LAT = 2;

endpackage
`default_nettype wire

// ===== hdl/nfcm_path.sv
// nfcm_path: one oscillator plus complex multiplier for a channel pair
`timescale 1ns/1ps
`default_nettype none
module nfcm_path
  import nfcm_pkg::*;
#(
  parameter int DATA_W = NFCM_DATA_W
)
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_sync,
  input wire logic [31:0] i_tuning,
  input wire logic [15:0] i_phase_shift,
  input wire logic i_mix_en,
  input wire logic i_gain_sel,
  input wire logic i_valid,
  input wire logic [DATA_W-1:0] i_re,
  input wire logic [DATA_W-1:0] i_im,
  output logic o_valid,
  output logic [DATA_W-1:0] o_re,
  output logic [DATA_W-1:0] o_im,
  output logic [31:0] o_phase_acc
);

  if (DATA_W != 16)
  begin : g_chk
    $error("nfcm_path: sine table is built for 16-bit samples only");
  end

  // ------------------------------------------------------------------
  // quarter-wave sine table, Q1.15, 16 steps per quadrant
  // ------------------------------------------------------------------
  localparam logic [15:0] NFCM_QTAB [0:16] = '{
    16'h0000, 16'h0C8C, 16'h18F9, 16'h2528, 16'h30FB, 16'h3C56, 16'h471C, 16'h5133,
    16'h5A82, 16'h62F1, 16'h6A6D, 16'h70E2, 16'h7641, 16'h7A7C, 16'h7D89, 16'h7F61,
    16'h7FFF};

  typedef struct packed {
    logic [31:0] acc;
    logic v1;
    logic byp1;
    logic gain1;
    logic [15:0] re1;
    logic [15:0] im1;
    logic [15:0] sin1;
    logic [15:0] cos1;
    logic v2;
    logic [15:0] re2;
    logic [15:0] im2;
  } nfcm_path_st_t;

  nfcm_path_st_t st_q;
  nfcm_path_st_t st_d;
  logic [31:0] phase;
  logic signed [31:0] p_ic;
  logic signed [31:0] p_qs;
  logic signed [31:0] p_is;
  logic signed [31:0] p_qc;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] nfcm_sine(input logic [5:0] ph);
    logic [15:0] mag;
    mag = ph[4] ? NFCM_QTAB[5'h10 - {1'b0, ph[3:0]}] : NFCM_QTAB[{1'b0, ph[3:0]}];
    return ph[5] ? 16'(-$signed(mag)) : mag;
  endfunction

  // symmetric clip keeps the negative limit at -32767 so I and Q stay balanced
  function automatic logic [15:0] nfcm_round_sat(input logic signed [32:0] sum,
                                                 input logic gain);
    logic signed [33:0] r;
    logic signed [33:0] sh;
    if (gain)
    begin
      r = 34'(sum) + 34'sh0000_4000;
      sh = r >>> 15;
    end
    else
    begin
      r = 34'(sum) + 34'sh0000_8000;
      sh = r >>> 16;
    end
    if (sh > 34'sh0000_7FFF)
      return 16'h7FFF;
    else if (sh < 34'sh3_FFFF_8001)
      return 16'h8001;
    else
      return sh[15:0];
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.acc = i_sync ? 32'h0000_0000 : st_q.acc + i_tuning;
    phase = st_q.acc + {i_phase_shift, 16'h0000};
    st_d.v1 = i_valid;
    st_d.byp1 = ~i_mix_en;
    st_d.gain1 = i_gain_sel;
    st_d.re1 = i_re;
    st_d.im1 = i_im;
    st_d.sin1 = nfcm_sine(phase[31:26]);
    st_d.cos1 = nfcm_sine(phase[31:26] + 6'h10);
    p_ic = $signed(st_q.re1) * $signed(st_q.cos1);
    p_qs = $signed(st_q.im1) * $signed(st_q.sin1);
    p_is = $signed(st_q.re1) * $signed(st_q.sin1);
    p_qc = $signed(st_q.im1) * $signed(st_q.cos1);
    st_d.v2 = st_q.v1;
    if (st_q.byp1)
    begin
      st_d.re2 = st_q.re1;
      st_d.im2 = st_q.im1;
    end
    else
    begin
      st_d.re2 = nfcm_round_sat(33'(p_ic) - 33'(p_qs), st_q.gain1);
      st_d.im2 = nfcm_round_sat(33'(p_is) + 33'(p_qc), st_q.gain1);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_valid = st_q.v2;
  assign o_re = st_q.re2;
  assign o_im = st_q.im2;
  assign o_phase_acc = st_q.acc;

endmodule
`default_nettype wire

// ===== dv/nfcm_src_model.sv
// nfcm_src_model: upstream sample source for one channel pair
`timescale 1ns/1ps
`default_nettype none
module nfcm_src_model
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_re,
  input wire logic [15:0] i_im,
  output logic o_valid,
  output logic [15:0] o_re,
  output logic [15:0] o_im
);
  // idle lines show the inverse of the held sample so a stale one never passes
  always @(posedge i_clk)
  begin
    o_valid <= i_go;
    o_re <= i_go ? i_re : ~i_re;
    o_im <= i_go ? i_im : ~i_im;
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
// tb: self-checking bench of the dual oscillator mixer
`timescale 1ns/1ps
`default_nettype none
module tb
  import nfcm_pkg::*;
  ;
  logic clk, rst, rd, wr, pin, aux, frm, c_gain, c_mix;
  logic [4:0] adr;
  logic [31:0] wd, d;
  logic [3:0] ben;
  logic [31:0] rdata;
  logic wreq, sev;
  logic [1:0] go;
  logic [15:0] sre[2], sim[2], mre[2], mim[2], ore[2], oim[2], c_shift;
  logic mv[2], ov[2];
  logic [63:0] e;
  logic [63:0] exq[2][$];
  int err_total, checks_done, cyc, clr_cyc, i, s, n, cap;
  logic [72:0] rrow[6] = '{{5'h00, 32'h12345678, 4'hF, 32'h12345678},
    {5'h00, 32'hAABBCCDD, 4'h3, 32'h1234CCDD}, {5'h04, 32'h89ABCDEF, 4'hC, 32'h89AB0000},
    {5'h08, 32'hFFFFBEEF, 4'hF, 32'h0000BEEF}, {5'h0C, 32'h00001234, 4'hF, 32'h00001234},
    {5'h10, 32'h0000002C, 4'h1, 32'h0000002C}};
  logic [49:0] srow[9] = '{{16'h0000, 2'b11, 16'h1234, 16'hF830},
    {16'h0000, 2'b01, 16'h7FFF, 16'h8000}, {16'h4000, 2'b11, 16'h0100, 16'h0200},
    {16'h4000, 2'b11, 16'h7FFF, 16'h8000}, {16'h8000, 2'b11, 16'h1000, 16'hF000},
    {16'h4000, 2'b00, 16'h8000, 16'h7FFF}, {16'h2000, 2'b11, 16'h7FFF, 16'h8000},
    {16'h2000, 2'b11, 16'h8000, 16'h7FFF}, {16'h0000, 2'b01, 16'h1234, 16'hF830}};

  nfcm_mixer_top i_nfcm_mixer_top (.i_clk(clk), .i_sys_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(ben),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_sync_pin(pin),
    .i_aux_sync_pin(aux), .i_frame_sync(frm), .i_ab_valid(mv[0]), .i_ab_re(mre[0]),
    .i_ab_im(mim[0]), .i_cd_valid(mv[1]), .i_cd_re(mre[1]), .i_cd_im(mim[1]),
    .o_ab_valid(ov[0]), .o_ab_re(ore[0]), .o_ab_im(oim[0]), .o_cd_valid(ov[1]),
    .o_cd_re(ore[1]), .o_cd_im(oim[1]), .o_sync_event(sev));
  nfcm_src_model i_src_ab (.i_clk(clk), .i_go(go[0]), .i_re(sre[0]), .i_im(sim[0]),
    .o_valid(mv[0]), .o_re(mre[0]), .o_im(mim[0]));
  nfcm_src_model i_src_cd (.i_clk(clk), .i_go(go[1]), .i_re(sre[1]), .i_im(sim[1]),
    .o_valid(mv[1]), .o_re(mre[1]), .o_im(mim[1]));

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one Avalon access; cap is the edge at which the request is first seen
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dw,
    input logic [3:0] be, output logic [31:0] q, output int c);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd <= dw;
    ben <= be;
    rd <= !w;
    wr <= w;
    @(posedge clk);
    c = cyc;
    while (wreq !== 1'b0 && k < 64)
    begin
      @(posedge clk);
      k++;
    end
    q = rdata;
    if (k == 64)
      check("bus answer", 0, 1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr32(input logic [4:0] a, input logic [31:0] dw, input logic [3:0] be);
    logic [31:0] q;
    int c;
    bus(1'b1, a, dw, be, q, c);
  endtask

  // zero, eighth, quarter and half turn only: those table points are known
  function automatic logic [15:0] mixv(input logic [15:0] x, input logic [15:0] y,
    input logic [15:0] sh, input logic imag);
    longint p, c, sn;
    c = (sh == 16'h4000) ? 0 : (sh == 16'h8000) ? -32767 : (sh == 16'h2000) ? 23170 : 32767;
    sn = (sh == 16'h4000) ? 32767 : (sh == 16'h2000) ? 23170 : 0;
    if (!c_mix)
      return imag ? y : x;
    if (imag)
      p = longint'($signed(x)) * sn + longint'($signed(y)) * c;
    else
      p = longint'($signed(x)) * c - longint'($signed(y)) * sn;
    p = c_gain ? (p + 16384) >>> 15 : (p + 32768) >>> 16;
    if (p > 32767)
      p = 32767;
    if (p < -32767)
      p = -32767;
    return p[15:0];
  endfunction

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      give_verdict();
    end
    for (int p = 0; p < 2; p++)
    begin
      if (ov[p] === 1'b1 && exq[p].size() == 0)
        check("spurious valid", 1, 0);
      else if (ov[p] === 1'b1)
      begin
        e = exq[p].pop_front();
        check("latency", cyc - e[63:32], NFCM_MIX_LAT);
        check("real out", ore[p], e[31:16]);
        check("imag out", oim[p], e[15:0]);
      end
      if (mv[p] === 1'b1)
        exq[p].push_back({cyc[31:0], mixv(mre[p], mim[p], p ? 16'h0000 : c_shift, 1'b0),
          mixv(mre[p], mim[p], p ? 16'h0000 : c_shift, 1'b1)});
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst, rd, wr, pin, aux, frm, adr, wd, ben, go} = '0;
    rst = 1'b1;
    sre = '{16'h0000, 16'h0000};
    sim = '{16'h0000, 16'h0000};
    c_shift = 16'h0000;
    {c_gain, c_mix} = 2'b11;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 8; i++)
    begin
      bus(1'b0, 5'(4 * i), 32'h0, 4'hF, d, cap);
      check("reset value", d, (i == 4) ? 32'h30 : 32'h0);
    end
    wr32(NFCM_OFS_ACC_AB, 32'hFFFFFFFF, 4'hF);
    bus(1'b0, NFCM_OFS_ACC_AB, 32'h0, 4'hF, d, cap);
    check("acc read only", d, 32'h0);
    $display("test reset done");
    foreach (rrow[r])
    begin
      wr32(rrow[r][72:68], rrow[r][67:36], rrow[r][35:32]);
      bus(1'b0, rrow[r][72:68], 32'h0, 4'hF, d, cap);
      check("register", d, rrow[r][31:0]);
    end
    $display("test registers done");
    wr32(NFCM_OFS_TUNING_AB, 32'hF0000001, 4'hF);
    wr32(NFCM_OFS_TUNING_CD, 32'h00001235, 4'hF);
    for (s = 0; s < 5; s++)
    begin
      wr32(NFCM_OFS_SYNC_CFG, (s == 4) ? 32'h30 : 32'h30 | (1 << s), 4'h1);
      if (s == 0 || s == 4)
        wr32(NFCM_OFS_SYNC_CFG, (s == 4) ? 32'h130 : 32'h131, 4'h3);
      @(posedge clk);
      pin <= (s == 1 || s == 4);
      frm <= (s == 2 || s == 4);
      aux <= (s == 3 || s == 4);
      n = 0;
      while (sev !== 1'b1 && n < 8)
      begin
        @(posedge clk);
        n++;
      end
      clr_cyc = (sev === 1'b1) ? cyc : -1;
      {pin, frm, aux} <= 3'b000;
      @(posedge clk);
      check("sync seen", clr_cyc >= 0, s < 4);
      bus(1'b0, NFCM_OFS_ACC_AB, 32'h0, 4'hF, d, cap);
      if (s < 4)
        check("acc ab", d, 32'hF0000001 * (cap - clr_cyc - 1));
      bus(1'b0, NFCM_OFS_ACC_CD, 32'h0, 4'hF, d, cap);
      if (s < 4)
        check("acc cd", d, 32'h00001235 * (cap - clr_cyc - 1));
    end
    $display("test sync done");
    wr32(NFCM_OFS_TUNING_AB, 32'h0, 4'hF);
    wr32(NFCM_OFS_TUNING_CD, 32'h0, 4'hF);
    wr32(NFCM_OFS_SHIFT_CD, 32'h0, 4'hF);
    wr32(NFCM_OFS_SYNC_CFG, 32'h131, 4'h3);
    foreach (srow[r])
    begin
      c_shift = srow[r][49:34];
      {c_gain, c_mix} = srow[r][33:32];
      wr32(NFCM_OFS_SHIFT_AB, {16'h0000, c_shift}, 4'hF);
      wr32(NFCM_OFS_SYNC_CFG, {26'h0, c_mix, c_gain, 4'h0}, 4'h1);
      @(posedge clk);
      go <= 2'b11;
      sre <= '{srow[r][31:16], srow[r][15:0]};
      sim <= '{srow[r][15:0], srow[r][31:16]};
      repeat (2) @(posedge clk);
      go <= 2'b00;
      repeat (5) @(posedge clk);
    end
    check("samples lost", exq[0].size() + exq[1].size(), 0);
    $display("test stream done");
    give_verdict();
  end
endmodule
`default_nettype wire
